/* File: common/smb_pkg.sv */
// Purpose: shared constants for the two-wire slave transaction engine and its master
// Assumes: system clock at SMB_SYS_MHZ
// Notes  : the inactivity count is large; the device takes it as a parameter
package smb_pkg;
    localparam logic [6:0] SMB_DEV_ADDR  = 7'h20;  // 0x40 as a write address byte
    localparam logic [7:0] SMB_CFG_ONE   = 8'hD1;  // interface_config_one
    localparam int         SMB_TO_EN_BIT = 3;      // bus_timeout_enable
    localparam logic [7:0] SMB_CFG_RST   = 8'h08;  // timeout on after reset
    localparam logic [7:0] SMB_BLK_CMD   = 8'hB0;  // command carried as a block
    localparam logic [7:0] SMB_BLK_LEN   = 8'h02;  // count sent on a block read
    localparam int         SMB_SYS_MHZ   = 100;
    localparam int         SMB_TO_MS     = 35;
    localparam int         SMB_TO_CYC    = SMB_TO_MS * 1000 * SMB_SYS_MHZ;
    localparam int         SMB_SCL_KHZ   = 100;
    // four quarter steps per clock period
    localparam int         SMB_TICK_CYC  = SMB_SYS_MHZ * 1000 / (SMB_SCL_KHZ * 4);

    // data bytes carried by a command code
    function automatic logic [1:0] smb_len(input logic [7:0] c);
        case (c)
            8'h03:                                    smb_len = 2'h0;
            8'h21, 8'h25, 8'h26, 8'h38, 8'h39,
            8'h4A, 8'h6A, 8'h79:                      smb_len = 2'h2;
            default:                                  smb_len = 2'h1;
        endcase
    endfunction
endpackage

/* File: common/smb_if.sv */
// Purpose: two-wire bus between master and slave ends
// Assumes: open drain; an enable low pulls the wire low
// Notes  : the wire levels are resolved here, never in the ends
`timescale 1ns/1ps
`default_nettype none
interface smb_if;
    logic scl_o;       // master clock value (always low)
    logic scl_oe_n;    // master clock pull, low pulls
    logic h_sda_o;     // master data value (always low)
    logic h_sda_oe_n;  // master data pull, low pulls
    logic d_sda_o;     // slave data value (always low)
    logic d_sda_oe_n;  // slave data pull, low pulls
    logic scl;         // resolved clock wire
    logic sda;         // resolved data wire

    // wired-and with pull-up
    assign scl = scl_oe_n | scl_o;
    assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);

    modport dev  (input scl, sda, output d_sda_o, d_sda_oe_n);
    modport host (input scl, sda, output scl_o, scl_oe_n, h_sda_o, h_sda_oe_n);
endinterface
`default_nettype wire

/* File: verilog/smb_host.sv */
// Purpose: bus master issuing write byte/word/block and read byte/word/block
// Assumes: single master, slave never stretches the clock
// Notes  : clock made from clk_sys by a divider, four steps per bit
`timescale 1ns/1ps
`default_nettype none
module smb_host
    import smb_pkg::*;
#(
    parameter int TICK = SMB_TICK_CYC  // clk_sys cycles per quarter bit
)(
    input  wire logic        clk_sys,    // system clock
    input  wire logic        resetn,     // async reset, active low
    smb_if.host              bus,        // two-wire bus
    input  wire logic        req_valid,  // request offered
    output logic             req_ready,  // idle, request taken
    input  wire logic        req_read,   // 1 read, 0 write
    input  wire logic [7:0]  req_cmd,    // command code
    input  wire logic [1:0]  req_cnt,    // block write byte count
    input  wire logic [23:0] req_data,   // write bytes, first in low byte
    output logic             rsp_valid,  // one-cycle pulse: transfer over
    output logic             rsp_nack,   // slave refused a byte
    output logic [23:0]      rsp_data    // read bytes, first in low byte
);
    localparam int TW = $clog2(TICK);
    typedef enum logic [2:0] {H_IDLE, H_START, H_FRAME, H_RSTART, H_STOP} smb_hst_type;
    typedef struct packed {
        logic [1:0]  sda;
        logic [TW-1:0] tick;
        logic [1:0]  ph;
        smb_hst_type st;
        logic [3:0]  bits;
        logic [2:0]  fi, rxi, rxn;
        logic        rdp, rd, blk;
        logic [7:0]  cmd, sh;
        logic [1:0]  cnt;
        logic [23:0] data;
        logic        scl_oen, sda_oen, ready, rsp_valid, rsp_nack;
        logic [23:0] rsp_data;
    } smb_hreg_type;

    smb_hreg_type hq, hn;
    logic [2:0] nw;
    logic [2:0] effn;
    logic [1:0] k;
    logic       tx;

    // byte sent in write frame number i
    function automatic logic [7:0] host_byte(input logic [2:0] i, input smb_hreg_type r);
        logic [2:0] j;
        j = i - 3'd2 - {2'b00, r.blk};
        if (i == 3'd0) host_byte = {SMB_DEV_ADDR, 1'b0};
        else if (i == 3'd1) host_byte = r.cmd;
        else if (r.blk && i == 3'd2) host_byte = {6'h00, r.cnt};
        else host_byte = r.data[{j[1:0], 3'b000} +: 8];
    endfunction

    // ***************************************************
    // sequencing
    // ***************************************************
    // frame counts; write phase of a read carries only address and command
    always_comb begin
        hn = hq;
        hn.rsp_valid = 1'b0;
        hn.sda = {hq.sda[0], bus.sda};
        nw = hq.rd ? 3'd2 : 3'd2 + {2'b00, hq.blk} + {1'b0, hq.blk ? hq.cnt : smb_len(hq.cmd)};
        effn = (hq.blk && hq.rxi == 3'd0) ? 3'd1 + ((hq.sh > 8'h03) ? 3'd3 : hq.sh[2:0]) : hq.rxn;
        k = 2'(hq.rxi - {2'b00, hq.blk});
        tx = !hq.rdp || hq.fi == 3'd0;
        if (hq.st == H_IDLE) begin
            hn.ready = 1'b1;
            hn.tick = '0;
            hn.ph = 2'h0;
            if (req_valid && hq.ready) begin
                hn.ready = 1'b0;
                hn.st = H_START;
                hn.rd = req_read;
                hn.cmd = req_cmd;
                hn.cnt = req_cnt;
                hn.blk = (req_cmd == SMB_BLK_CMD);
                hn.data = req_data;
                hn.rxn = {1'b0, smb_len(req_cmd)};
                hn.fi = 3'd0;
                hn.rxi = 3'd0;
                hn.rdp = 1'b0;
                hn.rsp_nack = 1'b0;
                hn.rsp_data = '0;
            end
        end else if (hq.tick != TW'(TICK - 1)) begin
            hn.tick = hq.tick + 1'b1;
        end else begin
            hn.tick = '0;
            hn.ph = hq.ph + 2'h1;
            case (hq.st)
                H_START: begin
                    case (hq.ph)
                        2'h0: begin hn.sda_oen = 1'b1; hn.scl_oen = 1'b1; end
                        2'h1: hn.sda_oen = 1'b0;
                        2'h2: hn.scl_oen = 1'b0;
                        default: begin
                            hn.st = H_FRAME;
                            hn.bits = 4'h0;
                            hn.sh = host_byte(3'd0, hq);
                        end
                    endcase
                end
                H_FRAME: begin
                    case (hq.ph)
                        2'h0: begin
                            if (tx) hn.sda_oen = (hq.bits == 4'd8) ? 1'b1 : hq.sh[7];
                            // ack every read byte but the last
                            else if (hq.bits == 4'd8) hn.sda_oen = (hq.rxi + 3'd1 == effn);
                            else hn.sda_oen = 1'b1;
                        end
                        2'h1: hn.scl_oen = 1'b1;
                        2'h2: begin
                            if (!tx && hq.bits != 4'd8) hn.sh = {hq.sh[6:0], hq.sda[1]};
                            if (tx && hq.bits == 4'd8) hn.rsp_nack = hq.sda[1];
                        end
                        default: begin
                            hn.scl_oen = 1'b0;
                            hn.bits = hq.bits + 4'h1;
                            if (hq.bits != 4'd8) begin
                                if (tx) hn.sh = {hq.sh[6:0], 1'b0};
                            end else begin
                                hn.bits = 4'h0;
                                if (tx && hq.rsp_nack) begin
                                    hn.st = H_STOP;
                                end else if (!hq.rdp) begin
                                    if (hq.fi + 3'd1 == nw) hn.st = hq.rd ? H_RSTART : H_STOP;
                                    hn.fi = hq.fi + 3'd1;
                                    hn.sh = host_byte(hq.fi + 3'd1, hq);
                                end else if (hq.fi == 3'd0) begin
                                    hn.fi = 3'd1;
                                end else begin
                                    if (hq.blk && hq.rxi == 3'd0) hn.rxn = effn;
                                    else hn.rsp_data[{k, 3'b000} +: 8] = hq.sh;
                                    hn.rxi = hq.rxi + 3'd1;
                                    if (hq.rxi + 3'd1 == effn) hn.st = H_STOP;
                                end
                            end
                        end
                    endcase
                end
                H_RSTART: begin
                    case (hq.ph)
                        2'h0: hn.sda_oen = 1'b1;
                        2'h1: hn.scl_oen = 1'b1;
                        2'h2: hn.sda_oen = 1'b0;
                        default: begin
                            hn.scl_oen = 1'b0;
                            hn.st = H_FRAME;
                            hn.rdp = 1'b1;
                            hn.fi = 3'd0;
                            hn.sh = {SMB_DEV_ADDR, 1'b1};
                        end
                    endcase
                end
                H_STOP: begin
                    case (hq.ph)
                        2'h0: hn.sda_oen = 1'b0;
                        2'h1: hn.scl_oen = 1'b1;
                        2'h2: hn.sda_oen = 1'b1;
                        default: begin
                            hn.st = H_IDLE;
                            hn.rsp_valid = 1'b1;
                        end
                    endcase
                end
                default: hn.st = H_IDLE;
            endcase
        end
    end

    // state register; bus released at reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hq <= '0;
            hq.scl_oen <= 1'b1;
            hq.sda_oen <= 1'b1;
        end else begin
            hq <= hn;
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.h_sda_o = 1'b0;
    assign bus.scl_oe_n = hq.scl_oen;
    assign bus.h_sda_oe_n = hq.sda_oen;
    assign req_ready = hq.ready;
    assign rsp_valid = hq.rsp_valid;
    assign rsp_nack = hq.rsp_nack;
    assign rsp_data = hq.rsp_data;
endmodule
`default_nettype wire

/* File: verilog/smb_dev.sv */
// Purpose: slave transaction engine for write byte/word/block, read byte/word/block
// Assumes: link_clk oversamples the bus well above the bus clock rate
// Notes  : protocol runs on link_clk, registers and timeout on clk_sys
//
// Summary of operation
// - start, 7-bit address, direction bit, acknowledge
// - write byte: command, one data, acknowledged
// - write word: command, two data bytes
// - block write: command, count, N bytes
// - read byte via repeated start, read address
// - master not-acknowledges single byte, then stop
// - word read sends low byte first
// - master acks first, nacks second byte
// - block read sends count then N bytes
// - master nacks last block byte, then stops
// - release bus after 35 ms inactivity
// - timeout enabled by config bit three
// - command code always acknowledged by device
// - answer only address 0x20
// - first byte loads pointer; needed before data
// - command code sets number of bytes
`timescale 1ns/1ps
`default_nettype none
module smb_dev
    import smb_pkg::*;
#(
    parameter int TO_CYC = SMB_TO_CYC  // idle clk_sys cycles before release
)(
    input  wire logic        clk_sys,   // register-side clock
    input  wire logic        resetn,    // async reset, active low
    input  wire logic        link_clk,  // link-side sampling clock
    smb_if.dev               bus,       // two-wire bus
    output logic             wr_valid,  // one-cycle pulse: write done
    output logic [7:0]       wr_cmd,    // command code of the write
    output logic [1:0]       wr_cnt,    // data bytes held in wr_data
    output logic [23:0]      wr_data,   // data bytes, first in low byte
    output logic [7:0]       rd_ptr,    // pointer that rd_data must answer
    input  wire logic [15:0] rd_data,   // word for rd_ptr, low byte first
    output logic [7:0]       cfg_one    // configuration register one
);
    localparam int CW = $clog2(TO_CYC);
    typedef enum logic [2:0] {L_IDLE, L_RX, L_DEC, L_ACK, L_TX, L_TXA, L_TXW} smb_lst_type;
    typedef struct packed {
        logic [2:0]  scl, sda, to, ak;  // [0],[1] synchroniser, [2] previous
        smb_lst_type st;
        logic [2:0]  bits, nb;
        logic [7:0]  sh, ptr;
        logic        addr, rd, ptr_ok, blk, oen, sdo;
        logic [1:0]  dcnt, txi;
        logic [23:0] data;
        logic [15:0] tx;
        logic        pt_tgl, wr_tgl;
        logic [7:0]  wr_cmd;
        logic [1:0]  wr_cnt;
        logic [23:0] wr_data;
    } smb_lnk_type;
    typedef struct packed {
        logic [2:0]  scl, sda, wr, pt;
        logic [CW-1:0] cnt;
        logic        to_tgl, ak_tgl, pend, wr_valid;
        logic [7:0]  cfg, rd_ptr, wr_cmd;
        logic [1:0]  wr_cnt;
        logic [23:0] wr_data;
        logic [15:0] hold;
    } smb_sys_type;

    smb_lnk_type lq, ln;
    smb_sys_type sq, sn;
    logic        scl_r, scl_f, start, stop;

    // byte number i of a read answer; past the command's length reads ones
    function automatic logic [7:0] tx_byte(input logic [1:0] i, input smb_lnk_type r);
        logic [1:0] j;
        j = i - {1'b0, r.blk};
        if (r.blk && i == 2'd0) tx_byte = SMB_BLK_LEN;
        else if (j >= smb_len(r.ptr) && !r.blk) tx_byte = 8'hFF;
        else if (j == 2'd0) tx_byte = r.tx[7:0];
        else if (j == 2'd1) tx_byte = r.tx[15:8];
        else tx_byte = 8'hFF;
    endfunction

    // ***************************************************
    // link side
    // ***************************************************
    // edges seen on the second synchroniser stage only
    assign scl_r = lq.scl[1] & ~lq.scl[2];
    assign scl_f = ~lq.scl[1] & lq.scl[2];
    assign start = lq.scl[1] & lq.scl[2] & lq.sda[2] & ~lq.sda[1];
    assign stop  = lq.scl[1] & lq.scl[2] & ~lq.sda[2] & lq.sda[1];

    // protocol engine; data is driven only on clock falls, released on clock falls, starts, stops and timeouts
    always_comb begin
        ln = lq;
        ln.scl = {lq.scl[1:0], bus.scl};
        ln.sda = {lq.sda[1:0], bus.sda};
        ln.to = {lq.to[1:0], sq.to_tgl};
        ln.ak = {lq.ak[1:0], sq.ak_tgl};
        // hold is steady by the time its toggle has crossed
        if (lq.ak[1] ^ lq.ak[2]) ln.tx = sq.hold;
        if (lq.to[1] ^ lq.to[2]) begin
            ln.st = L_IDLE;
            ln.oen = 1'b1;
            ln.nb = 3'd0;
            ln.ptr_ok = 1'b0;
        end else if (start) begin
            if (lq.st == L_IDLE) begin
                ln.nb = 3'd0;
                ln.ptr_ok = 1'b0;
                ln.blk = 1'b0;
                ln.dcnt = 2'd0;
            end
            ln.st = L_RX;
            ln.bits = 3'd0;
            ln.addr = 1'b1;
            ln.oen = 1'b1;
        end else if (stop) begin
            // a write with at least a command is handed to the register side
            if (!lq.rd && lq.nb != 3'd0) begin
                ln.wr_cmd = lq.ptr;
                ln.wr_cnt = lq.dcnt;
                ln.wr_data = lq.data;
                ln.wr_tgl = ~lq.wr_tgl;
            end
            ln.st = L_IDLE;
            ln.oen = 1'b1;
            ln.nb = 3'd0;
            ln.ptr_ok = 1'b0;
        end else begin
            case (lq.st)
                L_RX: if (scl_r) begin
                    ln.sh = {lq.sh[6:0], lq.sda[1]};
                    ln.bits = lq.bits + 3'd1;
                    if (lq.bits == 3'd7) ln.st = L_DEC;
                end
                L_DEC: if (scl_f) begin
                    ln.st = L_ACK;
                    ln.oen = 1'b0;
                    if (lq.addr) begin
                        ln.rd = lq.sh[0];
                        // reads need the pointer loaded first
                        if (lq.sh[7:1] != SMB_DEV_ADDR || (lq.sh[0] && !lq.ptr_ok)) begin
                            ln.st = L_IDLE;
                            ln.oen = 1'b1;
                        end
                    end else begin
                        ln.nb = (lq.nb == 3'd7) ? lq.nb : lq.nb + 3'd1;
                        if (lq.nb == 3'd0) begin
                            ln.ptr = lq.sh;
                            ln.ptr_ok = 1'b1;
                            ln.blk = (lq.sh == SMB_BLK_CMD);
                            ln.pt_tgl = ~lq.pt_tgl;
                        end else if (!(lq.blk && lq.nb == 3'd1) && lq.dcnt != 2'd3) begin
                            // bytes past three are acked and dropped
                            ln.data[{lq.dcnt, 3'b000} +: 8] = lq.sh;
                            ln.dcnt = lq.dcnt + 2'd1;
                        end
                    end
                end
                L_ACK: if (scl_f) begin
                    ln.addr = 1'b0;
                    ln.bits = 3'd0;
                    if (lq.rd) begin
                        ln.sh = tx_byte(2'd0, lq);
                        ln.oen = ln.sh[7];
                        ln.txi = 2'd0;
                        ln.st = L_TX;
                    end else begin
                        ln.oen = 1'b1;
                        ln.st = L_RX;
                    end
                end
                L_TX: if (scl_f) begin
                    ln.bits = lq.bits + 3'd1;
                    if (lq.bits == 3'd7) begin
                        ln.oen = 1'b1;
                        ln.st = L_TXA;
                    end else begin
                        ln.sh = {lq.sh[6:0], 1'b0};
                        ln.oen = lq.sh[6];
                    end
                end
                // a not-acknowledge ends the answer, the stop then follows
                L_TXA: if (scl_r) ln.st = lq.sda[1] ? L_IDLE : L_TXW;
                L_TXW: if (scl_f) begin
                    ln.txi = (lq.txi == 2'd3) ? lq.txi : lq.txi + 2'd1;
                    ln.sh = tx_byte(ln.txi, lq);
                    ln.oen = ln.sh[7];
                    ln.bits = 3'd0;
                    ln.st = L_TX;
                end
                default: ln.oen = 1'b1;
            endcase
        end
    end

    // link register; data line released at reset
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            lq <= '0;
            lq.oen <= 1'b1;
        end else begin
            lq <= ln;
        end
    end

    // ***************************************************
    // register side
    // ***************************************************
    // inactivity timer, pointer fetch and write delivery
    always_comb begin
        sn = sq;
        sn.wr_valid = 1'b0;
        sn.scl = {sq.scl[1:0], bus.scl};
        sn.sda = {sq.sda[1:0], bus.sda};
        sn.wr = {sq.wr[1:0], lq.wr_tgl};
        sn.pt = {sq.pt[1:0], lq.pt_tgl};
        if (!sq.cfg[SMB_TO_EN_BIT] || (sq.scl[1] ^ sq.scl[2]) || (sq.sda[1] ^ sq.sda[2])) begin
            sn.cnt = '0;
        end else if (sq.cnt == CW'(TO_CYC - 1)) begin
            sn.cnt = '0;
            sn.to_tgl = ~sq.to_tgl;
        end else begin
            sn.cnt = sq.cnt + 1'b1;
        end
        // link fields are stable for the whole time the toggle crosses
        if (sq.wr[1] ^ sq.wr[2]) begin
            sn.wr_valid = 1'b1;
            sn.wr_cmd = lq.wr_cmd;
            sn.wr_cnt = lq.wr_cnt;
            sn.wr_data = lq.wr_data;
            if (lq.wr_cmd == SMB_CFG_ONE && lq.wr_cnt != 2'd0) sn.cfg = lq.wr_data[7:0];
        end
        // user answers rd_ptr one cycle later, then the word goes back
        if (sq.pt[1] ^ sq.pt[2]) begin
            sn.rd_ptr = lq.ptr;
            sn.pend = 1'b1;
        end else if (sq.pend) begin
            sn.pend = 1'b0;
            sn.hold = (sq.rd_ptr == SMB_CFG_ONE) ? {8'h00, sq.cfg} : rd_data;
            sn.ak_tgl = ~sq.ak_tgl;
        end
    end

    // register-side state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sq <= '0;
            sq.cfg <= SMB_CFG_RST;
        end else begin
            sq <= sn;
        end
    end

    assign bus.d_sda_o = lq.sdo;
    assign bus.d_sda_oe_n = lq.oen;
    assign wr_valid = sq.wr_valid;
    assign wr_cmd = sq.wr_cmd;
    assign wr_cnt = sq.wr_cnt;
    assign wr_data = sq.wr_data;
    assign rd_ptr = sq.rd_ptr;
    assign cfg_one = sq.cfg;
endmodule
`default_nettype wire

/* File: tb/smb_chk_sva.sv */
// Purpose: wire checks for the two-wire bus
// Assumes: link_clk is far faster than scl
// Notes  : byte slot tracked from starts and scl rises
`timescale 1ns/1ps
`default_nettype none
module smb_chk (
    input wire logic link_clk,   // sampling clock
    input wire logic resetn,     // async reset, active low
    input wire logic scl,        // resolved clock wire
    input wire logic sda,        // resolved data wire
    input wire logic d_sda_o,    // slave data value
    input wire logic d_sda_oe_n  // slave data pull, low pulls
);
    typedef struct packed {
        logic       scl, sda, fb, wr, cmd, rd;
        logic [3:0] cnt;
        logic [7:0] sh;
    } smb_chk_type;
    smb_chk_type q, d;
    logic        rise, stop, start;
    // **********************
    // byte slot tracker
    // **********************
    assign rise = !q.scl & scl;
    assign stop = q.scl & scl & !q.sda & sda;
    assign start = q.scl & scl & q.sda & !sda;
    // a stop forgets the command, so a later read address is not owed an ack
    always_comb begin
        d = q;
        if (start) begin
            d = '{scl, sda, 1'b1, 1'b0, q.cmd, 1'b0, 4'h0, q.sh};
        end else if (stop) begin
            d = '{scl, sda, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, q.sh};
        end else if (rise) begin
            d.sh = {q.sh[6:0], sda};
            d.cnt = (q.cnt == 4'h8) ? 4'h0 : q.cnt + 4'h1;
            d.fb = q.fb & (q.cnt != 4'h8);
            if (q.cnt == 4'h8) begin
                d.wr = q.fb ? (q.sh == 8'h40) : q.wr;
                d.rd = q.fb ? (q.sh == 8'h41) & q.cmd : q.rd;
                d.cmd = q.cmd | (q.wr & !q.fb);
            end
        end
        d.scl = scl;
        d.sda = sda;
    end
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) q <= '0;
        else q <= d;
    end
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!resetn);
    property p_addr_quiet; rise && q.fb && q.cnt != 4'h8 |-> d_sda_oe_n; endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("pull in address");
    property p_ack_addr; rise && q.cnt == 4'h8 && q.fb && q.sh == 8'h40 |-> !d_sda_oe_n; endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("address not acked");
    property p_ack_rd; rise && q.cnt == 4'h8 && q.fb && q.sh == 8'h41 && q.cmd |-> !d_sda_oe_n;
    endproperty
    a_ack_rd: assert property (p_ack_rd) else $error("read address not acked");
    property p_data_ack; rise && q.cnt == 4'h8 && !q.fb && q.wr |-> !d_sda_oe_n; endproperty
    a_data_ack: assert property (p_data_ack) else $error("byte not acked");
    property p_rd_slot; rise && q.cnt == 4'h8 && !q.fb && q.rd |-> d_sda_oe_n; endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("master slot driven");
    property p_dev_hold; scl && q.scl |-> $stable(d_sda_oe_n); endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("data moved, clock high");
    property p_stop_free; stop |=> d_sda_oe_n [*4]; endproperty
    a_stop_free: assert property (p_stop_free) else $error("pull after stop");
    property p_dev_val; d_sda_o == 1'b0; endproperty
    a_dev_val: assert property (p_dev_val) else $error("data driven high");
endmodule
`default_nettype wire

/* File: tb/smbus_slave_transactions_tb.sv */
// Purpose: host and slave ends talking over one bus
// Assumes: short quarter step and inactivity count
// Notes  : inactivity release is neither driven nor checked; the checker has no idle rule
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_transactions_tb
    import smb_pkg::*;
;
    logic        clk_sys = 1'b0, link_clk = 1'b0, resetn = 1'b0, seen;
    logic        req_valid, req_ready, req_read, rsp_valid, rsp_nack, wr_valid;
    logic [1:0]  req_cnt, wr_cnt;
    logic [7:0]  req_cmd, wr_cmd, rd_ptr, cfg_one;
    logic [23:0] req_data, rsp_data, wr_data;
    logic [15:0] rd_data = 16'h0000;
    logic [33:0] cap;
    int          errors = 0, tests_run = 0;
    smb_if bus ();
    smb_host #(.TICK(8)) smb_host_inst (.clk_sys, .resetn, .bus(bus), .req_valid, .req_ready,
        .req_read, .req_cmd, .req_cnt, .req_data, .rsp_valid, .rsp_nack, .rsp_data);
    smb_dev #(.TO_CYC(2000)) smb_dev_inst (.clk_sys, .resetn, .link_clk, .bus(bus), .wr_valid,
        .wr_cmd, .wr_cnt, .wr_data, .rd_ptr, .rd_data, .cfg_one);
    smb_chk smb_chk_inst (.link_clk, .resetn, .scl(bus.scl), .sda(bus.sda),
        .d_sda_o(bus.d_sda_o), .d_sda_oe_n(bus.d_sda_oe_n));
    // **********************
    // clocks, register stand-in, helpers
    // **********************
    always #5 clk_sys = ~clk_sys;
    // odd offset keeps link edges off system edges
    initial #1.3 forever #3 link_clk = ~link_clk;
    function automatic logic [15:0] word_of(input logic [7:0] p);
        return {~p, p ^ 8'h5A};
    endfunction
    always @(negedge clk_sys) rd_data <= word_of(rd_ptr);
    always @(posedge clk_sys) if (wr_valid) {cap, seen} <= {wr_cmd, wr_cnt, wr_data, 1'b1};
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        int n = 0;
        do begin @(negedge clk_sys); n++; end while (s !== 1'b1 && n < lim);
        if (s !== 1'b1) begin errors++; give_verdict(); end
    endtask
    task automatic xfer(input logic rd, input logic [7:0] c, input logic [1:0] k);
        // offer only while ready stands, so the one next edge takes it
        wait_hi(req_ready, 100);
        {req_valid, req_read, req_cmd, req_cnt, req_data, seen} = {1'b1, rd, c, k, 24'h3C5AA5, 1'b0};
        @(negedge clk_sys);
        req_valid = 1'b0;
        wait_hi(rsp_valid, 5000);
        check(rsp_nack, 1'b0);
        if (!rd) wait_hi(seen, 50);
    endtask
    task automatic t_write();
        logic [7:0]  c[4] = '{8'h01, 8'h21, SMB_BLK_CMD, 8'h03};
        logic [1:0]  k[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic [23:0] m[4] = '{24'h0000FF, 24'h00FFFF, 24'hFFFFFF, 24'h000000};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, c[i], k[i]);
            check({cap[33:24], cap[23:0] & m[i]}, {c[i], k[i], 24'h3C5AA5 & m[i]});
        end
    endtask
    task automatic t_cfg();
        xfer(1'b0, SMB_CFG_ONE, 2'h1);
        check(cfg_one, 8'hA5);
        xfer(1'b1, SMB_CFG_ONE, 2'h0);
        check(rsp_data[7:0], 8'hA5);
    endtask
    task automatic t_read();
        xfer(1'b1, 8'h01, 2'h0);
        check(rsp_data[7:0], word_of(8'h01) & 16'h00FF);
        xfer(1'b1, 8'h21, 2'h0);
        check(rsp_data[15:0], word_of(8'h21));
        xfer(1'b1, SMB_BLK_CMD, 2'h0);
        check(rsp_data, {8'h00, word_of(SMB_BLK_CMD)});
        check(rd_ptr, SMB_BLK_CMD);
    endtask
    initial begin
        {req_valid, req_read, req_cmd, req_cnt, req_data, seen} = '0;
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(posedge clk_sys);
        check(cfg_one, SMB_CFG_RST);
        t_write();
        t_read();
        t_cfg();
        give_verdict();
    end
endmodule
`default_nettype wire
